//--- eirp_regs.svh
// register offsets, field positions, reset values and codes of the interrupt request port
`ifndef EIRP_REGS_SVH
`define EIRP_REGS_SVH

// ==================================================================
// register byte offsets
`define EIRP_OFF_MSI_CTRL    8'h00
`define EIRP_OFF_MSI_ADDR_LO 8'h04
`define EIRP_OFF_MSI_ADDR_HI 8'h08
`define EIRP_OFF_MSI_DATA    8'h0c
`define EIRP_OFF_IRQ_STATUS  8'h10
`define EIRP_OFF_IRQ_ENABLE  8'h14
`define EIRP_OFF_IRQ_CLEAR   8'h18
`define EIRP_OFF_PORT_STATE  8'h1c

// ==================================================================
// msi control field positions
`define EIRP_CTRL_EN_BIT     0
`define EIRP_CTRL_MMC_LSB    1
`define EIRP_CTRL_MME_LSB    4
`define EIRP_CTRL_CAP64_BIT  7
`define EIRP_CTRL_MASK_BIT   8

// ==================================================================
// reset values and hardware capabilities
`define EIRP_RST_MSI_EN      1'b0
`define EIRP_RST_MME         3'h0
`define EIRP_RST_MMC         3'h0
`define EIRP_RST_ADDR        32'h0000_0000
`define EIRP_RST_DATA        16'h0000
`define EIRP_RST_IRQ_EN      4'h0
`define EIRP_HW_CAP64        1'b1
`define EIRP_HW_MASK_CAP     1'b0
`define EIRP_MME_MAX         3'h5

// ==================================================================
// interrupt status bits and bus answers
`define EIRP_IRQ_MSI_SENT    0
`define EIRP_IRQ_INTX_SENT   1
`define EIRP_IRQ_MSI_REFUSED 2
`define EIRP_IRQ_PM_SENT     3
`define EIRP_RESP_OKAY       2'b00
`define EIRP_RESP_SLVERR     2'b10

`endif

//--- eirp_pkg.sv
// types shared by the interrupt request port modules
package eirp_pkg;

  // ==================================================================
  // request sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_OFFER = 3'b010,
    ST_WAIT  = 3'b100
  } eirp_state_e;

  // ==================================================================
  // outbound packet kinds
  typedef enum logic [1:0] {
    MSG_MSI        = 2'h0,
    MSG_ASSERT_A   = 2'h1,
    MSG_DEASSERT_A = 2'h2,
    MSG_PM_MSI     = 2'h3
  } eirp_kind_e;

  // posted write or message packet handed to the transmit path
  typedef struct packed {
    eirp_kind_e  kind;
    logic [2:0]  tc;
    logic        addr64;
    logic [63:0] addr;
    logic [31:0] data;
  } eirp_msg_s;

  // transmit slot state
  typedef struct packed {
    logic      full;
    logic      sent;
    eirp_msg_s msg;
  } eirp_tx_s;

endpackage : eirp_pkg

//--- eirp_sticky.sv
// sticky event bits with enable gating onto one level interrupt
`timescale 1ns/1ps
`default_nettype none

module eirp_sticky #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // events and software control
  input  wire logic [W-1:0] set_evt,
  input  wire logic [W-1:0] clr_req,
  input  wire logic [W-1:0] enable,
  // state
  output logic      [W-1:0] status,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
  } eirp_stk_s;

  eirp_stk_s st_reg;
  eirp_stk_s st_next;

  // a set arriving with its clear wins, so no event is lost
  always_comb begin
    st_next        = st_reg;
    st_next.status = (st_reg.status & ~clr_req) | set_evt;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status = st_reg.status;
  assign irq    = |(st_reg.status & enable);

endmodule : eirp_sticky

`default_nettype wire

//--- eirp_tx_slot.sv
// one-entry output slot; a packet counts as transmitted when the link takes it
`timescale 1ns/1ps
`default_nettype none

module eirp_tx_slot (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // from the sequencer
  input  wire logic               in_valid,
  input  wire eirp_pkg::eirp_msg_s in_msg,
  output logic                    in_ready,
  // toward the link
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output eirp_pkg::eirp_msg_s     tx_msg,
  // one-cycle pulse after the link took the packet
  output logic                    sent
);

  eirp_pkg::eirp_tx_s st_reg;
  eirp_pkg::eirp_tx_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.sent = 1'b0;
    if (st_reg.full && tx_ready) begin
      st_next.full = 1'b0;
      st_next.sent = 1'b1;
    end
    if (in_valid && !st_reg.full) begin
      st_next.full = 1'b1;
      st_next.msg  = in_msg;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = !st_reg.full;
  assign tx_valid = st_reg.full;
  assign tx_msg   = st_reg.msg;
  assign sent     = st_reg.sent;

endmodule : eirp_tx_slot

`default_nettype wire

//--- eirp_irq_port.sv
// endpoint interrupt request port: msi and legacy requests, msi control mirror, axi4-lite regs
`timescale 1ns/1ps
`default_nettype none
`include "eirp_regs.svh"

module eirp_irq_port (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // application msi request
  input  wire logic                msi_req,
  input  wire logic [2:0]          msi_traffic_class,
  input  wire logic [4:0]          msi_vector_offset,
  output logic                     msi_grant,
  // power management and hot-plug msi
  input  wire logic                pm_msi_event,
  input  wire logic [4:0]          pm_vector_offset,
  // legacy interrupt level and its acknowledge
  input  wire logic                legacy_int_level,
  output logic                     legacy_int_done,
  // msi control and status mirror
  output logic [15:0]              msi_ctrl_mirror,
  // outbound packets
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output eirp_pkg::eirp_msg_s      tx_msg,
  // interrupt to the local processor
  output logic                     irq,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // ==================================================================
  // state
  typedef struct packed {
    eirp_pkg::eirp_state_e state;
    eirp_pkg::eirp_kind_e  kind;
    eirp_pkg::eirp_msg_s   pend;
    logic                  sent_level;
    logic                  msi_armed;
    logic                  pm_pending;
    logic                  grant;
    logic                  done;
    logic                  refused;
    logic                  msi_en;
    logic [2:0]            mme;
    logic [2:0]            mmc;
    logic [31:0]           addr_lo;
    logic [31:0]           addr_hi;
    logic [15:0]           msg_data;
    logic [3:0]            irq_en;
    logic [3:0]            irq_clr;
    logic [7:0]            aw_addr;
    logic                  aw_have;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  w_have;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } eirp_top_s;

  eirp_top_s st_reg;
  eirp_top_s st_next;

  // ==================================================================
  // helpers
  logic                slot_ready;
  logic                slot_sent;
  logic [3:0]          irq_status;
  logic [3:0]          irq_events;
  logic [15:0]         ctrl_word;

  // byte-lane merge of a write onto the old register value
  function automatic logic [31:0] eirp_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  wstrb);
    logic [31:0] lanes;
    lanes = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    return (old_val & ~lanes) | (wdata & lanes);
  endfunction : eirp_merge

  // offsets beyond the allocated vectors are folded, so the data stays in range
  function automatic logic [4:0] eirp_vec_mask(input logic [2:0] mme);
    return 5'((6'h01 << mme) - 6'h01);
  endfunction : eirp_vec_mask

  // build an msi write from the msi settings
  function automatic eirp_pkg::eirp_msg_s eirp_build_msi(input eirp_top_s s,
                                                         input eirp_pkg::eirp_kind_e k,
                                                         input logic [2:0] tc,
                                                         input logic [4:0] off);
    eirp_pkg::eirp_msg_s m;
    m.kind   = k;
    m.tc     = tc;
    m.addr64 = `EIRP_HW_CAP64 && (s.addr_hi != 32'h0000_0000);
    m.addr   = {(`EIRP_HW_CAP64 ? s.addr_hi : 32'h0000_0000), s.addr_lo};
    m.data   = {16'h0000, s.msg_data + {11'h000, off & eirp_vec_mask(s.mme)}};
    return m;
  endfunction : eirp_build_msi

  // ==================================================================
  // msi control word
  always_comb begin
    ctrl_word                               = 16'h0000;
    ctrl_word[`EIRP_CTRL_MASK_BIT]          = `EIRP_HW_MASK_CAP;
    ctrl_word[`EIRP_CTRL_CAP64_BIT]         = `EIRP_HW_CAP64;
    ctrl_word[`EIRP_CTRL_MME_LSB +: 3]      = st_reg.mme;
    ctrl_word[`EIRP_CTRL_MMC_LSB +: 3]      = st_reg.mmc;
    ctrl_word[`EIRP_CTRL_EN_BIT]            = st_reg.msi_en;
  end

  // ==================================================================
  // next state
  always_comb begin
    logic [31:0] wval;
    logic [31:0] rval;
    logic        rok;
    logic        wok;
    logic        want_intx;
    wval      = 32'h0000_0000;
    rval      = 32'h0000_0000;
    rok       = 1'b1;
    wok       = 1'b1;
    want_intx = legacy_int_level != st_reg.sent_level;
    st_next           = st_reg;
    st_next.grant     = 1'b0;
    st_next.done      = 1'b0;
    st_next.refused   = 1'b0;
    st_next.irq_clr   = 4'h0;

    // request is re-armed only once the application has dropped it
    if (!msi_req) begin
      st_next.msi_armed = 1'b1;
    end
    if (pm_msi_event) begin
      st_next.pm_pending = 1'b1;
    end
    unique case (st_reg.state)
      eirp_pkg::ST_IDLE: begin
        if (want_intx) begin
          st_next.kind  = legacy_int_level ? eirp_pkg::MSG_ASSERT_A
                                           : eirp_pkg::MSG_DEASSERT_A;
          st_next.pend      = '0;
          st_next.pend.kind = st_next.kind;
          st_next.sent_level = legacy_int_level;
          st_next.state = eirp_pkg::ST_OFFER;
        end else if (msi_req && st_reg.msi_armed) begin
          st_next.msi_armed = 1'b0;
          if (st_reg.msi_en) begin
            st_next.kind  = eirp_pkg::MSG_MSI;
            st_next.pend  = eirp_build_msi(st_reg, eirp_pkg::MSG_MSI,
                                           msi_traffic_class, msi_vector_offset);
            st_next.state = eirp_pkg::ST_OFFER;
          end else begin
            // disabled: grant so the application is not stuck, send nothing
            st_next.grant   = 1'b1;
            st_next.refused = 1'b1;
          end
        end else if (st_reg.pm_pending && st_reg.msi_en) begin
          st_next.pm_pending = pm_msi_event;
          st_next.kind  = eirp_pkg::MSG_PM_MSI;
          st_next.pend  = eirp_build_msi(st_reg, eirp_pkg::MSG_PM_MSI,
                                         3'h0, pm_vector_offset);
          st_next.state = eirp_pkg::ST_OFFER;
        end
      end
      eirp_pkg::ST_OFFER: begin
        if (slot_ready) begin
          st_next.state = eirp_pkg::ST_WAIT;
        end
      end
      eirp_pkg::ST_WAIT: begin
        if (slot_sent) begin
          st_next.state = eirp_pkg::ST_IDLE;
          if (st_reg.kind == eirp_pkg::MSG_MSI) begin
            st_next.grant = 1'b1;
          end
          if (st_reg.kind inside {eirp_pkg::MSG_ASSERT_A, eirp_pkg::MSG_DEASSERT_A}) begin
            st_next.done = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = eirp_pkg::ST_IDLE;
      end
    endcase
    if (s_axi_awvalid && !st_reg.aw_have) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_have) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      unique case (st_reg.aw_addr)
        `EIRP_OFF_MSI_CTRL: begin
          wval = eirp_merge({16'h0000, ctrl_word}, st_reg.w_data, st_reg.w_strb);
          st_next.msi_en = wval[`EIRP_CTRL_EN_BIT];
          st_next.mmc    = wval[`EIRP_CTRL_MMC_LSB +: 3];
          // reserved allocation codes are ignored, the old count stays
          if (wval[`EIRP_CTRL_MME_LSB +: 3] <= `EIRP_MME_MAX) begin
            st_next.mme = wval[`EIRP_CTRL_MME_LSB +: 3];
          end
        end
        `EIRP_OFF_MSI_ADDR_LO: begin
          wval = eirp_merge(st_reg.addr_lo, st_reg.w_data, st_reg.w_strb);
          st_next.addr_lo = {wval[31:2], 2'b00};
        end
        `EIRP_OFF_MSI_ADDR_HI: begin
          st_next.addr_hi = eirp_merge(st_reg.addr_hi, st_reg.w_data, st_reg.w_strb);
        end
        `EIRP_OFF_MSI_DATA: begin
          wval = eirp_merge({16'h0000, st_reg.msg_data}, st_reg.w_data, st_reg.w_strb);
          st_next.msg_data = wval[15:0];
        end
        `EIRP_OFF_IRQ_ENABLE: begin
          wval = eirp_merge({28'h0000000, st_reg.irq_en}, st_reg.w_data, st_reg.w_strb);
          st_next.irq_en = wval[3:0];
        end
        `EIRP_OFF_IRQ_CLEAR: begin
          st_next.irq_clr = st_reg.w_strb[0] ? st_reg.w_data[3:0] : 4'h0;
        end
        `EIRP_OFF_IRQ_STATUS, `EIRP_OFF_PORT_STATE: begin
          wok = 1'b1;
        end
        default: begin
          wok = 1'b0;
        end
      endcase
      st_next.bresp = wok ? `EIRP_RESP_OKAY : `EIRP_RESP_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      unique case (s_axi_araddr)
        `EIRP_OFF_MSI_CTRL:    rval = {16'h0000, ctrl_word};
        `EIRP_OFF_MSI_ADDR_LO: rval = st_reg.addr_lo;
        `EIRP_OFF_MSI_ADDR_HI: rval = st_reg.addr_hi;
        `EIRP_OFF_MSI_DATA:    rval = {16'h0000, st_reg.msg_data};
        `EIRP_OFF_IRQ_STATUS:  rval = {28'h0000000, irq_status};
        `EIRP_OFF_IRQ_ENABLE:  rval = {28'h0000000, st_reg.irq_en};
        `EIRP_OFF_IRQ_CLEAR:   rval = 32'h0000_0000;
        `EIRP_OFF_PORT_STATE:  rval = {26'h0000000, st_reg.msi_armed, st_reg.pm_pending,
                                       st_reg.sent_level, st_reg.state};
        default: begin
          rval = 32'h0000_0000;
          rok  = 1'b0;
        end
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata  = rval;
      st_next.rresp  = rok ? `EIRP_RESP_OKAY : `EIRP_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // ==================================================================
  // registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg          <= '0;
      st_reg.state    <= eirp_pkg::ST_IDLE;
      st_reg.msi_en   <= `EIRP_RST_MSI_EN;
      st_reg.mme      <= `EIRP_RST_MME;
      st_reg.mmc      <= `EIRP_RST_MMC;
      st_reg.addr_lo  <= `EIRP_RST_ADDR;
      st_reg.addr_hi  <= `EIRP_RST_ADDR;
      st_reg.msg_data <= `EIRP_RST_DATA;
      st_reg.irq_en   <= `EIRP_RST_IRQ_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==================================================================
  // transmit slot and event bits
  eirp_tx_slot u_slot (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .in_valid (st_reg.state == eirp_pkg::ST_OFFER),
    .in_msg   (st_reg.pend),
    .in_ready (slot_ready),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_msg   (tx_msg),
    .sent     (slot_sent)
  );

  always_comb begin
    irq_events = 4'h0;
    irq_events[`EIRP_IRQ_MSI_SENT]    = st_reg.grant && !st_reg.refused;
    irq_events[`EIRP_IRQ_INTX_SENT]   = st_reg.done;
    irq_events[`EIRP_IRQ_MSI_REFUSED] = st_reg.refused;
    irq_events[`EIRP_IRQ_PM_SENT]     = slot_sent && st_reg.kind == eirp_pkg::MSG_PM_MSI;
  end

  eirp_sticky #(
    .W (4)
  ) u_sticky (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set_evt (irq_events),
    .clr_req (st_reg.irq_clr),
    .enable  (st_reg.irq_en),
    .status  (irq_status),
    .irq     (irq)
  );

  // ==================================================================
  // outputs
  assign msi_grant       = st_reg.grant;
  assign legacy_int_done = st_reg.done;
  assign msi_ctrl_mirror = ctrl_word;
  assign s_axi_awready   = !st_reg.aw_have;
  assign s_axi_wready    = !st_reg.w_have;
  assign s_axi_bvalid    = st_reg.bvalid;
  assign s_axi_bresp     = st_reg.bresp;
  assign s_axi_arready   = !st_reg.rvalid;
  assign s_axi_rvalid    = st_reg.rvalid;
  assign s_axi_rdata     = st_reg.rdata;
  assign s_axi_rresp     = st_reg.rresp;

endmodule : eirp_irq_port

`default_nettype wire

//--- eirp_irq_port_asserts.sv
// concurrent checks on the interrupt request port top
`timescale 1ns/1ps
`default_nettype none

module eirp_irq_port_asserts (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                reset,
  // watched outputs and link handshake
  input wire logic                msi_grant,
  input wire logic                legacy_int_done,
  input wire logic [15:0]         msi_ctrl_mirror,
  input wire logic                tx_valid,
  input wire logic                tx_ready,
  input wire eirp_pkg::eirp_msg_s tx_msg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==================================================================
  // helpers
  logic leg_take;
  assign leg_take = tx_valid && tx_ready
    && (tx_msg.kind inside {eirp_pkg::MSG_ASSERT_A, eirp_pkg::MSG_DEASSERT_A});

  sequence s_msi_take;
    tx_valid && tx_ready && tx_msg.kind == eirp_pkg::MSG_MSI;
  endsequence

  // ==================================================================
  // properties
  chk_mirror_fixed: assert property (msi_ctrl_mirror[15:7] == 9'h001)
    else $error("mirror fixed bits wrong");
  chk_mme_legal: assert property (msi_ctrl_mirror[6:4] <= 3'h5)
    else $error("reserved enabled count code");
  chk_pkt_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg))
    else $error("offered packet changed");
  chk_msi_grant: assert property (s_msi_take |-> ##2 msi_grant)
    else $error("no grant after msi sent");
  chk_grant_pulse: assert property (msi_grant |=> !msi_grant)
    else $error("grant longer than a cycle");
  chk_done_after: assert property (leg_take |-> ##2 legacy_int_done)
    else $error("no done after legacy message");
  chk_done_cause: assert property (legacy_int_done |-> $past(leg_take, 2))
    else $error("done without legacy message");
  chk_msi_enabled: assert property (s_msi_take |-> msi_ctrl_mirror[0])
    else $error("msi sent while disabled");
endmodule : eirp_irq_port_asserts

`default_nettype wire

//--- eirp_link_model.sv
// link side model: takes offered packets after a set stall, keeps the last one
`timescale 1ns/1ps
`default_nettype none

module eirp_link_model (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // packets from the port
  input  wire logic                tx_valid,
  input  wire eirp_pkg::eirp_msg_s tx_msg,
  output logic                     tx_ready,
  // pacing and capture
  input  wire logic [3:0]          stall,
  output eirp_pkg::eirp_msg_s      got,
  output int unsigned              n
);
  logic [3:0] w;
  // ready only rises while a packet waits, so an idle link never looks eager
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_ready <= 1'b0;
      w        <= 4'h0;
      n        <= 0;
      got      <= '0;
    end else if (tx_valid && tx_ready) begin
      got      <= tx_msg;
      n        <= n + 1;
      tx_ready <= 1'b0;
      w        <= 4'h0;
    end else if (tx_valid) begin
      w        <= w + 4'h1;
      tx_ready <= (w >= stall);
    end
  end
endmodule : eirp_link_model

`default_nettype wire

//--- eirp_irq_port_test.sv
// self-checking bench of the interrupt request port
`timescale 1ns/1ps
`default_nettype none
`include "eirp_regs.svh"

module eirp_irq_port_test;
  logic ref_clk, reset, msi_req, msi_grant, pm_msi_event, legacy_int_level, legacy_int_done;
  logic tx_valid, tx_ready, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [2:0]          msi_traffic_class;
  logic [4:0]          msi_vector_offset, pm_vector_offset;
  logic [15:0]         msi_ctrl_mirror;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata, rd;
  logic [1:0]          bresp, rresp, resp;
  logic [3:0]          stall;
  eirp_pkg::eirp_msg_s tx_msg, got;
  int unsigned         n;
  int                  err_total = 0;
  int                  checked = 0;

  eirp_irq_port eirp_irq_port_i (.ref_clk(ref_clk), .reset(reset), .msi_req(msi_req),
    .msi_traffic_class(msi_traffic_class), .msi_vector_offset(msi_vector_offset),
    .msi_grant(msi_grant), .pm_msi_event(pm_msi_event), .pm_vector_offset(pm_vector_offset),
    .legacy_int_level(legacy_int_level), .legacy_int_done(legacy_int_done),
    .msi_ctrl_mirror(msi_ctrl_mirror), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_msg(tx_msg), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  eirp_link_model eirp_link_model_i (.ref_clk(ref_clk), .reset(reset), .tx_valid(tx_valid),
    .tx_msg(tx_msg), .tx_ready(tx_ready), .stall(stall), .got(got), .n(n));

  // ==================================================================
  // tasks
  task chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task axw(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    resp = bresp;
    // idle edge so a following call never drives bready twice in one step
    @(posedge ref_clk);
  endtask : axw

  task axr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
    @(posedge ref_clk);
  endtask : axr

  // request held until the grant, then dropped
  task msi(input logic [2:0] tc, input logic [4:0] off);
    msi_traffic_class <= tc;
    msi_vector_offset <= off;
    msi_req           <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (msi_grant === 1'b1) break;
    end
    msi_req <= 1'b0;
  endtask : msi

  task wait_done;
    forever begin
      @(posedge ref_clk);
      if (legacy_int_done === 1'b1) break;
    end
  endtask : wait_done

  task print_verdict;
    $display("counts: %0d checked, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ==================================================================
  // clock, watchdog, tests
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #50us;
    err_total++;
    print_verdict();
  end

  initial begin
    {msi_req, pm_msi_event, legacy_int_level, awvalid, wvalid, bready, arvalid, rready} = '0;
    {msi_traffic_class, msi_vector_offset, pm_vector_offset, awaddr, araddr, wdata} = '0;
    stall = 4'h3;
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    axr(`EIRP_OFF_MSI_CTRL);
    chk(rd, 32'h0000_0080);
    chk(msi_ctrl_mirror, 16'h0080);
    axw(`EIRP_OFF_MSI_CTRL, 32'h0000_0025);
    chk(msi_ctrl_mirror, 16'h00a5);
    axw(`EIRP_OFF_MSI_ADDR_LO, 32'h8000_0013);
    axw(`EIRP_OFF_MSI_ADDR_HI, 32'h0000_0001);
    axw(`EIRP_OFF_MSI_DATA, 32'h0000_1230);
    axw(`EIRP_OFF_IRQ_ENABLE, 32'h0000_000f);
    axr(`EIRP_OFF_MSI_ADDR_LO);
    chk(rd, 32'h8000_0010);
    $display("test registers done");
    // offset 6 with four vectors allocated keeps only its low two bits
    msi(3'h5, 5'h06);
    chk(n, 1);
    chk(got.kind, eirp_pkg::MSG_MSI);
    chk(got.tc, 3'h5);
    chk(got.data, 32'h0000_1232);
    chk(got.addr64, 1'b1);
    chk(got.addr, 64'h0000_0001_8000_0010);
    // status bit lands on the edge that shows the grant
    @(posedge ref_clk);
    chk(irq, 1'b1);
    axw(`EIRP_OFF_IRQ_CLEAR, 32'h0000_000f);
    axr(`EIRP_OFF_IRQ_STATUS);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    $display("test msi done");
    stall <= 4'h0;
    legacy_int_level <= 1'b1;
    wait_done();
    chk(got.kind, eirp_pkg::MSG_ASSERT_A);
    legacy_int_level <= 1'b0;
    wait_done();
    chk(got.kind, eirp_pkg::MSG_DEASSERT_A);
    chk(n, 3);
    $display("test legacy done");
    axw(`EIRP_OFF_MSI_CTRL, 32'h0000_0024);
    msi(3'h1, 5'h00);
    chk(n, 3);
    axr(`EIRP_OFF_IRQ_STATUS);
    chk(rd, 32'h0000_0006);
    pm_vector_offset <= 5'h1f;
    pm_msi_event <= 1'b1;
    @(posedge ref_clk);
    pm_msi_event <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(n, 3);
    axw(`EIRP_OFF_MSI_CTRL, 32'h0000_0025);
    repeat (60) begin
      @(posedge ref_clk);
      if (n == 4) break;
    end
    chk(got.kind, eirp_pkg::MSG_PM_MSI);
    chk(got.data, 32'h0000_1233);
    $display("test disabled and pm done");
    axr(8'h20);
    chk(resp, `EIRP_RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h20, 32'h0000_0001);
    chk(resp, `EIRP_RESP_SLVERR);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : eirp_irq_port_test

bind eirp_irq_port eirp_irq_port_asserts eirp_irq_port_asserts_i (.ref_clk, .reset,
  .msi_grant, .legacy_int_done, .msi_ctrl_mirror, .tx_valid, .tx_ready, .tx_msg);

`default_nettype wire
